// ---- acspi_defs.svh ----
// Constants for the accelerometer serial command port.
// Assumes inclusion by bare name from the package and modules.
`ifndef ACSPI_DEFS_SVH
`define ACSPI_DEFS_SVH
// ----------------------------------------
// Instructions
// ----------------------------------------
`define ACSPI_INS_ACCEL    8'h50
`define ACSPI_INS_TEMP     8'h54
`define ACSPI_INS_ADV4     8'h58
`define ACSPI_INS_ADV8     8'h78
`define ACSPI_INS_ADV2     8'h7C
// ----------------------------------------
// Argument lengths in bytes
// ----------------------------------------
`define ACSPI_LEN2         4'h2
`define ACSPI_LEN4         4'h4
`define ACSPI_LEN8         4'h8
// ----------------------------------------
// Frame layout and timing
// ----------------------------------------
`define ACSPI_NEW_BIT      7
`define ACSPI_INTEG_BIT    6
`define ACSPI_BASE_RATE_HZ 1900
`define ACSPI_CLK_HZ       250000000
`define ACSPI_BASE_CYCLES  (`ACSPI_CLK_HZ / `ACSPI_BASE_RATE_HZ)
`define ACSPI_STARTUP_CYC  64
`endif

// ---- acspi_pkg.sv ----
// Types for the accelerometer serial command port.
// Assumes acspi_defs.svh is on the include path.
`include "acspi_defs.svh"
package acspi_pkg;
  typedef enum logic [1:0] {
    ACSPI_IDLE = 2'b00,
    ACSPI_INS  = 2'b01,
    ACSPI_ARG  = 2'b11,
    ACSPI_SKIP = 2'b10
  } acspi_state_e;

  typedef struct packed {
    logic [23:0] gravitySample;
    logic        newSampleFlag;
    logic        integrityFlag;
  } acspi_sample_s;
endpackage : acspi_pkg

// ---- acspi_sync.sv ----
// Two-flop synchroniser bank for the serial pins.
// Assumes inputs are asynchronous to clock.
module acspi_sync #(
  parameter int W = 3
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta   <= '0;
      synced <= '0;
    end else begin
      meta   <= async;
      synced <= meta;
    end
  end
endmodule : acspi_sync

// ---- acspi_port.sv ----
// Serial slave command port of a single-axis accelerometer.
// Assumes the host master drives the link pins; sample source is on clock.
// Operation
// - Slave only, clock idles low, data sampled on rising edge.
// - Output released whenever select is high.
// - Frame is one instruction byte then 2, 4 or 8 argument bytes.
// - 0x50 reads acceleration over four bytes; 0x54 reads temperature over two.
// - 0x58 takes four bytes, 0x78 eight, 0x7C two.
// - Acceleration answer is 32 bits: 24-bit sample, two status bits, then six zero bits.
// - Sample is signed two's complement.
// - Compensated sample counts one millionth of g per lsb.
// - Uncompensated sample delivered when compensation is off.
// - New-sample flag set on new sample, held until sample read.
// - Integrity bit mirrors integrity pin, refreshed each output sample.
// - Link and loop health continuously checked into integrity status.
// - Start-up check of digital blocks before normal operation; the code only waits STARTUP_CYC clocks and checks nothing.
// - Health status updates together with each new sample.
// - Select is active low; port responds only while low.
// - Data-ready pin pulses once per new sample.
// - Integrity pin high when healthy, low otherwise.
// - Sample rate is 1900 Hz over divider plus one.
module acspi_port
  import acspi_pkg::*;
#(
  parameter int BASE_CYCLES = `ACSPI_BASE_CYCLES,
  parameter int STARTUP_CYC = `ACSPI_STARTUP_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        selectN,
  output logic             miso,
  output logic             misoOeN,
  input  wire logic [23:0] compSample,
  input  wire logic [23:0] rawSample,
  input  wire logic        compEnable,
  input  wire logic        loopHealthy,
  input  wire logic [13:0] tempWord,
  input  wire logic [5:0]  rate_divider_value,
  output logic             dataReady,
  output logic             integrityPin,
  output logic [7:0]       advInstr,
  output logic [63:0]      advArg,
  output logic             advValid,
  output logic             advShortFrame
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pinSync;
  acspi_sync #(.W(3)) uSync (
    .clock  (clock),
    .rst    (rst),
    .async  ({sclk, mosi, ~selectN}),
    .synced (pinSync)
  );
  wire sclkS   = pinSync[2];
  wire mosiS   = pinSync[1];
  // Select travels inverted so reset reads as deselected, miso released
  wire selNS   = ~pinSync[0];
  logic sclkD;
  wire  rise   = sclkS & ~sclkD;
  wire  fall   = ~sclkS & sclkD;
  wire  active = ~selNS;

  // ----------------------------------------
  // Sample timing and health
  // ----------------------------------------
  logic [31:0]   rateCnt;
  logic [7:0]    startCnt;
  logic          startDone;
  logic          linkError;
  acspi_sample_s sample;
  wire [31:0] period  = BASE_CYCLES * (32'(rate_divider_value) + 32'd1);
  wire        tick    = startDone && (rateCnt >= period - 32'd1);
  wire        healthy = startDone & loopHealthy & ~linkError;
  logic       readDone;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startCnt  <= '0;
      startDone <= 1'b0;
    end else if (!startDone) begin
      startCnt  <= startCnt + 8'd1;
      startDone <= (startCnt == 8'(STARTUP_CYC - 1));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) rateCnt <= '0;
    else if (tick || !startDone) rateCnt <= '0;
    else rateCnt <= rateCnt + 32'd1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sample       <= '0;
      dataReady    <= 1'b0;
      integrityPin <= 1'b0;
    end else begin
      dataReady <= tick;
      if (tick) begin
        sample.gravitySample <= compEnable ? compSample : rawSample;
        sample.integrityFlag <= healthy;
        integrityPin         <= healthy;
      end
      // New sample wins over a read that completes in the same cycle
      if (tick) sample.newSampleFlag <= 1'b1;
      else if (readDone) sample.newSampleFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  acspi_state_e state;
  logic [7:0]   shiftIn;
  logic [2:0]   bitCnt;
  logic [3:0]   byteCnt;
  logic [3:0]   argLen;
  logic [7:0]   instr;
  logic [63:0]  argShift;
  logic [31:0]  txShift;
  wire  [7:0]   rxByte = {shiftIn[6:0], mosiS};
  wire          byteEnd = rise && bitCnt == 3'd7;

  logic [3:0] decLen;
  logic       decOk;
  always_comb begin
    decOk = 1'b1;
    unique case (rxByte)
      `ACSPI_INS_ACCEL: decLen = `ACSPI_LEN4;
      `ACSPI_INS_TEMP:  decLen = `ACSPI_LEN2;
      `ACSPI_INS_ADV4:  decLen = `ACSPI_LEN4;
      `ACSPI_INS_ADV8:  decLen = `ACSPI_LEN8;
      `ACSPI_INS_ADV2:  decLen = `ACSPI_LEN2;
      default: begin
        decLen = 4'h0;
        decOk  = 1'b0;
      end
    endcase
  end

  wire [31:0] accelFrame = {sample.gravitySample, sample.newSampleFlag,
                            sample.integrityFlag, 6'h00};
  wire [31:0] tempFrame  = {2'b00, tempWord, 16'h0000};
  wire        frameDone  = state == ACSPI_ARG && byteEnd && byteCnt == argLen - 4'd1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= ACSPI_IDLE;
      sclkD    <= 1'b0;
      shiftIn  <= '0;
      bitCnt   <= '0;
      byteCnt  <= '0;
      argLen   <= '0;
      instr    <= '0;
      argShift <= '0;
      txShift  <= '0;
      miso     <= 1'b0;
      readDone <= 1'b0;
      linkError <= 1'b0;
      advInstr <= '0;
      advArg   <= '0;
      advValid <= 1'b0;
      advShortFrame <= 1'b0;
    end else begin
      sclkD    <= sclkS;
      readDone <= 1'b0;
      advValid <= 1'b0;
      if (!active) begin
        // Frame aborted inside its argument counts as a link fault
        if (state == ACSPI_ARG) linkError <= 1'b1;
        state   <= ACSPI_IDLE;
        bitCnt  <= '0;
        byteCnt <= '0;
        miso    <= 1'b0;
      end else begin
        if (state == ACSPI_IDLE) state <= ACSPI_INS;
        if (rise) begin
          shiftIn <= rxByte;
          bitCnt  <= bitCnt + 3'd1;
          if (state == ACSPI_ARG) argShift <= {argShift[62:0], mosiS};
        end
        if (fall && state == ACSPI_ARG) begin
          miso    <= txShift[31];
          txShift <= {txShift[30:0], 1'b0};
        end
        if (byteEnd && state == ACSPI_INS) begin
          instr   <= rxByte;
          // Stale bits of a longer frame must not leak into a short one
          argShift <= '0;
          argLen  <= decLen;
          byteCnt <= '0;
          state   <= decOk ? ACSPI_ARG : ACSPI_SKIP;
          linkError <= ~decOk;
          txShift <= (rxByte == `ACSPI_INS_TEMP) ? tempFrame : accelFrame;
          // First argument bit must be valid before the first rising edge
          miso    <= (rxByte == `ACSPI_INS_TEMP) ? tempFrame[31] : accelFrame[31];
        end else if (byteEnd && state == ACSPI_ARG) begin
          byteCnt <= byteCnt + 4'd1;
        end
        if (fall && state == ACSPI_INS && bitCnt == 3'd0 && byteCnt == 4'd0) begin
          miso    <= txShift[31];
        end
        if (frameDone) begin
          state     <= ACSPI_SKIP;
          linkError <= 1'b0;
          readDone  <= (instr == `ACSPI_INS_ACCEL);
          advValid  <= (instr != `ACSPI_INS_ACCEL) && (instr != `ACSPI_INS_TEMP);
          advInstr  <= instr;
          advArg    <= {argShift[62:0], mosiS};
          advShortFrame <= (argLen != `ACSPI_LEN8);
        end
      end
    end
  end

  assign misoOeN = selNS;
endmodule : acspi_port

// ---- acspi_port_sva.sv ----
// Assertions on the command port pins.
// Assumes it is bound into acspi_port.
`include "acspi_defs.svh"
module acspi_port_sva #(
  parameter int BASE_CYCLES = `ACSPI_BASE_CYCLES,
  parameter int STARTUP_CYC = `ACSPI_STARTUP_CYC
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       selectN,
  input wire logic       misoOeN,
  input wire logic       loopHealthy,
  input wire logic [5:0] rate_divider_value,
  input wire logic       dataReady,
  input wire logic       integrityPin,
  input wire logic [7:0] advInstr,
  input wire logic       advValid,
  input wire logic       advShortFrame
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  int   gap;
  int   up;
  logic armed;
  // Divider change voids the interval in flight
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap <= 0;
      up <= 0;
      armed <= 1'b0;
    end else begin
      gap <= dataReady ? 1 : gap + 1;
      up <= up + 1;
      armed <= $stable(rate_divider_value) && (armed || dataReady);
    end
  end
  sequence s_off; selectN [*4]; endsequence
  sequence s_on; !selectN [*4]; endsequence
  sequence s_sick; !loopHealthy [*3] ##0 dataReady; endsequence
  a_oe_released: assert property (s_off |-> misoOeN)
    else $error("miso enabled while deselected");
  a_oe_driven: assert property (s_on |-> !misoOeN)
    else $error("miso released while selected");
  a_ready_pulse: assert property (dataReady |=> !dataReady [*8])
    else $error("data ready not a single pulse");
  a_tick_period: assert property (dataReady && armed |-> gap == BASE_CYCLES * (rate_divider_value + 1))
    else $error("sample period wrong");
  a_startup_quiet: assert property (dataReady |-> up >= STARTUP_CYC + BASE_CYCLES)
    else $error("sample before start-up check");
  a_health_low: assert property (s_sick |-> ##[0:1] !integrityPin)
    else $error("integrity high while loop unhealthy");
  a_status_tick: assert property (!$stable(integrityPin) |-> dataReady || $past(dataReady))
    else $error("integrity moved off a sample tick");
  a_adv_length: assert property (advValid |-> (advShortFrame == (advInstr != `ACSPI_INS_ADV8)) ##1 !advValid)
    else $error("advanced frame length flag wrong");
endmodule : acspi_port_sva
bind acspi_port acspi_port_sva #(.BASE_CYCLES(BASE_CYCLES), .STARTUP_CYC(STARTUP_CYC)) chk (
  .clock(clock), .rst(rst), .selectN(selectN), .misoOeN(misoOeN), .loopHealthy(loopHealthy),
  .rate_divider_value(rate_divider_value), .dataReady(dataReady), .integrityPin(integrityPin),
  .advInstr(advInstr), .advValid(advValid), .advShortFrame(advShortFrame));

// ---- acspi_host.sv ----
// Host serial master model, clock idle low, data changed on the fall.
// Assumes the bench clock; HALF is half a link period in clocks.
module acspi_host #(
  parameter int HALF = 20
) (
  input  wire logic clock,
  input  wire logic miso,
  input  wire logic misoOeN,
  output logic      sclk,
  output logic      mosi,
  output logic      selectN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastMiso = 1'b0;
  // Released line shows the inverse, never a stale copy
  wire misoBus = misoOeN ? ~lastMiso : miso;
  always @(posedge clock) if (!misoOeN) lastMiso <= miso;
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    selectN = 1'b1;
  end
  task automatic frame(input logic [7:0] ins, input int nBytes, input logic [63:0] arg, output logic [63:0] rx);
    rx = '0;
    @(posedge clock) selectN <= 1'b0;
    repeat (2 * HALF) @(posedge clock);
    for (int i = 0; i < 8 + 8 * nBytes; i++) begin
      mosi <= i < 8 ? ins[7-i] : arg[8*nBytes+7-i];
      repeat (HALF) @(posedge clock);
      sclk <= 1'b1;
      if (i >= 8) rx = {rx[62:0], misoBus};
      repeat (HALF) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (2 * HALF) @(posedge clock);
    selectN <= 1'b1;
    mosi <= ~mosi;
    repeat (2 * HALF) @(posedge clock);
  endtask : frame
endmodule : acspi_host

// ---- accel_spi_command_port_tb_top.sv ----
// Bench for the accelerometer command port with random samples.
// Assumes acspi_host and the bound checker are compiled alongside.
`include "acspi_defs.svh"
module accel_spi_command_port_tb_top
  import acspi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [23:0] compSample = 24'h00_0000;
  logic [23:0] rawSample = 24'h00_0000;
  logic        compEnable = 1'b1;
  logic        loopHealthy = 1'b1;
  logic [13:0] tempWord = 14'h0000;
  logic [5:0]  rate_divider_value = 6'h00;
  logic        sclk, mosi, selectN, miso, misoOeN, dataReady, integrityPin, advValid, advShortFrame;
  logic [7:0]  advInstr;
  logic [63:0] advArg;
  logic [72:0] gotAdv;
  int          advSeen = 0;
  int          mismatches = 0;
  int          compares = 0;
  always #2 clock = ~clock;
  always @(posedge clock) if (advValid) begin
    advSeen <= advSeen + 1;
    gotAdv <= {advShortFrame, advInstr, advArg};
  end
  acspi_port #(.BASE_CYCLES(100), .STARTUP_CYC(4)) dut (
    .clock(clock), .rst(rst), .sclk(sclk), .mosi(mosi), .selectN(selectN), .miso(miso), .misoOeN(misoOeN),
    .compSample(compSample), .rawSample(rawSample), .compEnable(compEnable), .loopHealthy(loopHealthy),
    .tempWord(tempWord), .rate_divider_value(rate_divider_value), .dataReady(dataReady),
    .integrityPin(integrityPin), .advInstr(advInstr), .advArg(advArg), .advValid(advValid),
    .advShortFrame(advShortFrame));
  acspi_host host (.clock(clock), .miso(miso), .misoOeN(misoOeN), .sclk(sclk), .mosi(mosi), .selectN(selectN));
  function automatic logic [31:0] accel_word(logic en, logic [23:0] c, logic [23:0] r, logic nf);
    acspi_sample_s s;
    s = '{en ? c : r, nf, 1'b1};
    return {s, 6'h00};
  endfunction : accel_word
  task automatic check(input string what, input logic [72:0] exp, input logic [72:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (dataReady !== 1'b1 && n < 20000);
    if (dataReady !== 1'b1) begin
      mismatches++;
      $display("[FAIL] dataReady expected 1 seen %b", dataReady);
      end_sim();
    end
  endtask : wait_tick
  initial begin
    int          n;
    logic [63:0] rx;
    logic [63:0] arg;
    int          divs[3] = '{0, 1, 5};
    int          lens[3] = '{4, 8, 2};
    logic [7:0]  ins[3] = '{`ACSPI_INS_ADV4, `ACSPI_INS_ADV8, `ACSPI_INS_ADV2};
    void'($urandom(98584));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    foreach (divs[k]) begin
      @(posedge clock) rate_divider_value <= 6'(divs[k]);
      repeat (3) wait_tick(n);
      check("period", 100 * (divs[k] + 1), n);
    end
    @(posedge clock) rate_divider_value <= 6'd49;
    repeat (2) wait_tick(n);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      compEnable <= i != 1;
      compSample <= i == 0 ? 24'h0F_4240 : 24'($urandom);
      rawSample <= i == 1 ? 24'hF0_BDC0 : 24'($urandom);
      wait_tick(n);
      host.frame(`ACSPI_INS_ACCEL, 4, 0, rx);
      check("accel", accel_word(compEnable, compSample, rawSample, 1), rx);
      host.frame(`ACSPI_INS_ACCEL, 4, 0, rx);
      check("reread", accel_word(compEnable, compSample, rawSample, 0), rx);
    end
    @(posedge clock) tempWord <= 14'($urandom);
    host.frame(`ACSPI_INS_TEMP, 2, 0, rx);
    check("temp", {2'b00, tempWord}, rx);
    for (int k = 0; k < 3; k++) begin
      n = advSeen;
      arg = {$urandom, $urandom} >> (64 - 8 * lens[k]);
      host.frame(ins[k], lens[k], arg, rx);
      check("adv", {lens[k] != 8, ins[k], arg}, gotAdv);
      check("adv count", n + 1, advSeen);
    end
    @(posedge clock) rate_divider_value <= 6'd5;
    host.frame(8'h33, 2, 0, rx);
    repeat (2) wait_tick(n);
    check("integrity bad frame", 0, integrityPin);
    host.frame(`ACSPI_INS_TEMP, 2, 0, rx);
    repeat (2) wait_tick(n);
    check("integrity restored", 1, integrityPin);
    // Frame cut short inside its argument
    n = advSeen;
    host.frame(`ACSPI_INS_ADV8, 2, 0, rx);
    check("adv count cut", n, advSeen);
    repeat (2) wait_tick(n);
    check("integrity cut frame", 0, integrityPin);
    @(posedge clock) loopHealthy <= 1'b0;
    repeat (2) wait_tick(n);
    check("integrity unhealthy", 0, integrityPin);
    end_sim();
  end
endmodule : accel_spi_command_port_tb_top
